// File: core/pcei_pad_config_ext_irq.sv
`timescale 1ns/1ps
`default_nettype none
module pcei_pad_config_ext_irq (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire pcei_pkg::pcei_addr_t i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // fieldbus receive pin
    input wire logic i_fbrx_pin,
    output logic o_fbrx_rx,
    output logic o_fbrx_pullup_en,
    // external interrupt requests
    input wire logic i_low_power,
    input wire logic i_ext_int_req_a,
    input wire logic i_ext_int_req_b,
    output logic o_irq_pullup_en,
    output logic o_ext_wake,
    output logic o_irq,
    // shared timer / port e pins
    input wire pcei_pkg::pcei_pe_t i_port_e_in,
    output pcei_pkg::pcei_pe_t o_port_e_out,
    output pcei_pkg::pcei_pe_t o_port_e_oe,
    output pcei_pkg::pcei_pe_t o_port_e_pullup_en,
    input wire pcei_pkg::pcei_pe_t i_timer_out,
    input wire pcei_pkg::pcei_pe_t i_timer_oe,
    output pcei_pkg::pcei_pe_t o_timer_in
);
    import pcei_pkg::*;

    // ------------------------------------------------------------------
    // registers and wires
    // ------------------------------------------------------------------
    logic [PUD_W-1:0] pullup_disable_reg;
    pcei_pe_t port_e_pullup_enable_reg;
    pcei_pe_t pe_sel;
    pcei_pe_t pe_dir;
    pcei_pe_t pe_dout;
    pcei_irq_t irq_edge;
    pcei_irq_t int_stat;
    pcei_irq_t int_en;
    pcei_irq_t int_clr;
    pcei_irq_t req;
    pcei_irq_t req_pin;
    pcei_pe_t pe_meta;
    pcei_pe_t pe_sync;
    logic fbrx_meta;
    logic fbrx_sync;
    logic apb_setup;
    logic apb_wr;
    logic [31:0] next_prdata;
    logic next_pslverr;

    assign apb_setup = i_psel & ~i_penable;
    assign apb_wr = i_psel & i_penable & i_pwrite;
    assign req_pin = {i_ext_int_req_b, i_ext_int_req_a};

    // ------------------------------------------------------------------
    // apb write side
    // ------------------------------------------------------------------
    // zero wait states, so every access phase completes in its first cycle
    assign o_pready = i_psel & i_penable;

    // pull-up disable bits: all clear, so every pull-up is on after reset
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            pullup_disable_reg <= PUD_RST;
        end else if (apb_wr && i_paddr == OFF_PUD) begin
            pullup_disable_reg <= i_pwdata[PUD_W-1:0];
        end
    end

    // port e pull-up enables, opposite polarity to the disable register
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            port_e_pullup_enable_reg <= PEPU_RST;
        end else if (apb_wr && i_paddr == OFF_PEPU) begin
            port_e_pullup_enable_reg <= i_pwdata[PE_N-1:0];
        end
    end

    // pin function, direction and output data
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            pe_sel <= PESEL_RST;
            pe_dir <= PEDIR_RST;
            pe_dout <= PEDO_RST;
        end else if (apb_wr) begin
            if (i_paddr == OFF_PESEL) begin
                pe_sel <= i_pwdata[PE_N-1:0];
            end
            if (i_paddr == OFF_PEDIR) begin
                pe_dir <= i_pwdata[PE_N-1:0];
            end
            if (i_paddr == OFF_PEDO) begin
                pe_dout <= i_pwdata[PE_N-1:0];
            end
        end
    end

    // request sensitivity and interrupt enables
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            irq_edge <= IRQCFG_RST;
            int_en <= IEN_RST;
        end else if (apb_wr) begin
            if (i_paddr == OFF_IRQCFG) begin
                irq_edge <= i_pwdata[IRQ_N-1:0];
            end
            if (i_paddr == OFF_IEN) begin
                int_en <= i_pwdata[IRQ_N-1:0];
            end
        end
    end

    // write-one-to-clear strobe, lasts the access cycle only
    assign int_clr = (apb_wr && i_paddr == OFF_ICLR) ? i_pwdata[IRQ_N-1:0] : '0;

    // ------------------------------------------------------------------
    // apb read side
    // ------------------------------------------------------------------
    // data is fetched in the setup cycle so it comes from a flip-flop;
    // status read therefore shows the value one cycle before the access
    always_comb begin
        next_prdata = '0;
        next_pslverr = 1'b0;
        unique case (i_paddr)
            OFF_PUD: next_prdata[PUD_W-1:0] = pullup_disable_reg;
            OFF_PEPU: next_prdata[PE_N-1:0] = port_e_pullup_enable_reg;
            OFF_PESEL: next_prdata[PE_N-1:0] = pe_sel;
            OFF_PEDIR: next_prdata[PE_N-1:0] = pe_dir;
            OFF_PEDO: next_prdata[PE_N-1:0] = pe_dout;
            OFF_PEDI: next_prdata[PE_N-1:0] = pe_sync;
            OFF_IRQCFG: next_prdata[IRQ_N-1:0] = irq_edge;
            OFF_ISTAT: next_prdata[IRQ_N-1:0] = int_stat;
            OFF_ICLR: next_prdata = '0;
            OFF_IEN: next_prdata[IRQ_N-1:0] = int_en;
            default: next_pslverr = 1'b1;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_prdata <= '0;
            o_pslverr <= 1'b0;
        end else if (apb_setup) begin
            o_prdata <= i_pwrite ? 32'h0000_0000 : next_prdata;
            o_pslverr <= next_pslverr;
        end
    end

    // ------------------------------------------------------------------
    // pull-up controls
    // ------------------------------------------------------------------
    assign o_fbrx_pullup_en = ~pullup_disable_reg[PUD_FBRX];
    assign o_irq_pullup_en = ~pullup_disable_reg[PUD_IRQ];
    assign o_port_e_pullup_en = port_e_pullup_enable_reg;

    // ------------------------------------------------------------------
    // pin input synchronisers
    // ------------------------------------------------------------------
    // fieldbus receive goes to its controller synchronised
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            fbrx_meta <= SYNC_IDLE;
            fbrx_sync <= SYNC_IDLE;
        end else begin
            fbrx_meta <= i_fbrx_pin;
            fbrx_sync <= fbrx_meta;
        end
    end
    assign o_fbrx_rx = fbrx_sync;

    // one synchroniser per shared pin; timer and gpio read the same copy
    genvar gp;
    generate
        for (gp = 0; gp < PE_N; gp++) begin : g_pe_sync
            always_ff @(posedge i_clk_sys) begin
                if (i_srst) begin
                    pe_meta[gp] <= 1'b0;
                    pe_sync[gp] <= 1'b0;
                end else begin
                    pe_meta[gp] <= i_port_e_in[gp];
                    pe_sync[gp] <= pe_meta[gp];
                end
            end
        end
    endgenerate
    assign o_timer_in = pe_sync;

    // ------------------------------------------------------------------
    // shared pin routing
    // ------------------------------------------------------------------
    // select bit low hands the pad to the timer channel, high to gpio
    genvar gm;
    generate
        for (gm = 0; gm < PE_N; gm++) begin : g_pe_mux
            assign o_port_e_out[gm] = pe_sel[gm] ? pe_dout[gm] : i_timer_out[gm];
            assign o_port_e_oe[gm] = pe_sel[gm] ? pe_dir[gm] : i_timer_oe[gm];
        end
    endgenerate

    // ------------------------------------------------------------------
    // external interrupt request conditioning
    // ------------------------------------------------------------------
    // the outside device pulls the line low to ask, see the request mode
    genvar gi;
    generate
        for (gi = 0; gi < IRQ_N; gi++) begin : g_irq
            pcei_irq_cond u_cond (
                .i_clk_sys(i_clk_sys),
                .i_srst(i_srst),
                .i_pin(req_pin[gi]),
                .i_edge_mode(irq_edge[gi]),
                .o_req(req[gi])
            );
        end
    endgenerate

    // sticky status, a new request beats a clear in the same cycle
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            int_stat <= ISTAT_RST;
        end else begin
            int_stat <= (int_stat & ~int_clr) | req;
        end
    end

    assign o_irq = |(int_stat & int_en);

    // stop and wait may halt the clock, so wake comes straight from the pins;
    // this path is deliberately unsynchronised and unfiltered
    assign o_ext_wake = i_low_power & |(int_en & ~req_pin);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_wr(pcei_addr_t a);
        i_psel && i_penable && i_pwrite && i_paddr == a;
    endsequence

    sequence s_rst_release;
        i_srst ##1 !i_srst;
    endsequence

    reset_defaults_a: assert property (@(posedge i_clk_sys)
        s_rst_release |-> o_fbrx_pullup_en && o_irq_pullup_en && (&o_port_e_pullup_en))
        else $error("pull-ups not on after reset");

    timer_after_reset_a: assert property (@(posedge i_clk_sys)
        s_rst_release |-> (o_port_e_oe == i_timer_oe) && (o_port_e_out == i_timer_out))
        else $error("shared pins not on timer after reset");

    fbrx_pud_wr_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        s_wr(OFF_PUD) |=> (o_fbrx_pullup_en == !$past(i_pwdata[PUD_FBRX])))
        else $error("fieldbus pull-up does not follow disable bit");

    irq_pud_wr_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        (s_wr(OFF_PUD) and i_pwdata[PUD_IRQ]) |=> !o_irq_pullup_en)
        else $error("request pull-ups stay on after disable");

    pe_pullup_wr_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        s_wr(OFF_PEPU) |=> (o_port_e_pullup_en == $past(i_pwdata[PE_N-1:0])))
        else $error("port e pull-up enables wrong after write");

    gpio_dir_wr_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        (s_wr(OFF_PEDIR) and (&pe_sel)) |=> (o_port_e_oe == $past(i_pwdata[PE_N-1:0])))
        else $error("gpio direction not applied to pin enables");

    level_sync_lat_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        (!irq_edge[IRQ_A] && !i_ext_int_req_a) [*3] |=> int_stat[IRQ_A])
        else $error("level request not latched three cycles after line low");

    high_no_req_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        (!irq_edge[IRQ_B] && i_ext_int_req_b) [*3] |-> !req[IRQ_B])
        else $error("level request raised while line high");

    status_sticky_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        (int_stat[IRQ_A] && !int_clr[IRQ_A]) |=> int_stat[IRQ_A])
        else $error("pending request lost without clear");

    async_wake_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        (i_low_power && int_en[IRQ_B] && !i_ext_int_req_b) |-> o_ext_wake)
        else $error("no wake from low line in low-power mode");

    irq_out_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        (int_stat[IRQ_A] && int_en[IRQ_A]) |-> o_irq)
        else $error("enabled pending status without interrupt");

    apb_zero_wait_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        (i_psel && !i_penable) ##1 (i_psel && i_penable) |-> o_pready)
        else $error("access phase not answered in its first cycle");

    // status bits: a new request beats a clear, an idle bit clears
    sequence s_clr_hit(int b);
        int_clr[b] && req[b];
    endsequence

    set_beats_clr_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        s_clr_hit(IRQ_A) |=> int_stat[IRQ_A])
        else $error("request lost to a clear in the same cycle");

    clr_drops_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        (int_clr[IRQ_B] && !req[IRQ_B]) |=> !int_stat[IRQ_B])
        else $error("status bit survives its clear");

    edge_one_shot_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        (irq_edge[IRQ_B] && req[IRQ_B]) |=> !req[IRQ_B])
        else $error("edge request lasts more than one cycle");

    irq_quiet_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        !(|(int_stat & int_en)) |-> !o_irq)
        else $error("interrupt raised with nothing pending");

    // routing and wake, checked against the inputs that feed them
    timer_sel_wr_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        (s_wr(OFF_PESEL) and !i_pwdata[0]) |=> (o_port_e_oe[0] == i_timer_oe[0]))
        else $error("pin zero left on gpio after timer select");

    gpio_out_wr_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        (s_wr(OFF_PEDO) and pe_sel[1]) |=> (o_port_e_out[1] == $past(i_pwdata[1])))
        else $error("gpio data not driven on pin one");

    wake_needs_lp_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        !i_low_power |-> !o_ext_wake)
        else $error("wake raised outside low-power mode");

endmodule : pcei_pad_config_ext_irq
`default_nettype wire

// File: core/pcei_pkg.sv
package pcei_pkg;

    // ------------------------------------------------------------------
    // widths and types
    // ------------------------------------------------------------------
    localparam int PE_N = 6;
    localparam int IRQ_N = 2;
    typedef logic [7:0] pcei_addr_t;
    typedef logic [PE_N-1:0] pcei_pe_t;
    typedef logic [IRQ_N-1:0] pcei_irq_t;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam pcei_addr_t OFF_PUD = 8'h00;   // pullup_disable_reg
    localparam pcei_addr_t OFF_PEPU = 8'h04;  // port_e_pullup_enable_reg
    localparam pcei_addr_t OFF_PESEL = 8'h08; // port e function select
    localparam pcei_addr_t OFF_PEDIR = 8'h0c; // port e direction
    localparam pcei_addr_t OFF_PEDO = 8'h10;  // port e data out
    localparam pcei_addr_t OFF_PEDI = 8'h14;  // port e pin level, read only
    localparam pcei_addr_t OFF_IRQCFG = 8'h18; // request sensitivity
    localparam pcei_addr_t OFF_ISTAT = 8'h1c; // interrupt status, read only
    localparam pcei_addr_t OFF_ICLR = 8'h20;  // interrupt clear, write only
    localparam pcei_addr_t OFF_IEN = 8'h24;   // interrupt enable

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int PUD_W = 2;
    localparam int PUD_FBRX = 0;
    localparam int PUD_IRQ = 1;
    localparam int IRQ_A = 0;
    localparam int IRQ_B = 1;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [PUD_W-1:0] PUD_RST = 2'h0;
    localparam pcei_pe_t PEPU_RST = 6'h3f;
    localparam pcei_pe_t PESEL_RST = 6'h00;
    localparam pcei_pe_t PEDIR_RST = 6'h00;
    localparam pcei_pe_t PEDO_RST = 6'h00;
    localparam pcei_irq_t IRQCFG_RST = 2'h0;
    localparam pcei_irq_t IEN_RST = 2'h0;
    localparam pcei_irq_t ISTAT_RST = 2'h0;
    localparam logic SYNC_IDLE = 1'b1;

endpackage : pcei_pkg

// File: core/pcei_irq_cond.sv
`timescale 1ns/1ps
`default_nettype none
module pcei_irq_cond (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_pin,
    input wire logic i_edge_mode,
    output logic o_req
);
    import pcei_pkg::*;

    logic meta;
    logic sync;
    logic prev;

    // ------------------------------------------------------------------
    // two-stage synchroniser plus history stage
    // ------------------------------------------------------------------
    // idle level is high so a released line never looks like a request
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            meta <= SYNC_IDLE;
            sync <= SYNC_IDLE;
            prev <= SYNC_IDLE;
        end else begin
            meta <= i_pin;
            sync <= meta;
            prev <= sync;
        end
    end

    // level mode asks while low, edge mode only on the high-to-low step
    assign o_req = i_edge_mode ? (prev & ~sync) : ~sync;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    edge_only_fall_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        (i_edge_mode && o_req) |-> ($past(sync) && !sync))
        else $error("edge request without falling edge");
    level_low_req_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        (!i_edge_mode && !i_pin) [*3] |-> o_req)
        else $error("level request missing after line held low");

endmodule : pcei_irq_cond
`default_nettype wire

// File: tb/pcei_ext_model.sv
`timescale 1ns/1ps
`default_nettype none
module pcei_ext_model (
    input wire logic i_clk_sys,
    input wire logic [1:0] i_hold_low,
    input wire logic i_irq_pullup_en,
    input wire logic i_fb_drive,
    input wire logic i_fb_val,
    input wire logic i_fb_pullup_en,
    input wire pcei_pkg::pcei_pe_t i_pe_out,
    input wire pcei_pkg::pcei_pe_t i_pe_oe,
    input wire pcei_pkg::pcei_pe_t i_pe_ext,
    output logic o_req_a,
    output logic o_req_b,
    output logic o_fb_pin,
    output pcei_pkg::pcei_pe_t o_pe_pad
);
    import pcei_pkg::*;
    logic float_q = 1'b0;

    // ------------------------------------------------------------------
    // far side pins
    // ------------------------------------------------------------------
    // a released line without pull-up wanders, so it never keeps its old level
    always @(posedge i_clk_sys) begin
        float_q <= ~float_q;
    end

    // requesters only pull low; on release the pull-up or noise takes over
    always_comb begin
        o_req_a = i_hold_low[0] ? 1'b0 : (i_irq_pullup_en ? 1'b1 : float_q);
        o_req_b = i_hold_low[1] ? 1'b0 : (i_irq_pullup_en ? 1'b1 : float_q);
        o_fb_pin = i_fb_drive ? i_fb_val : (i_fb_pullup_en ? 1'b1 : float_q);
        o_pe_pad = (i_pe_oe & i_pe_out) | (~i_pe_oe & i_pe_ext);
    end
endmodule : pcei_ext_model
`default_nettype wire

// File: tb/pcei_pad_config_ext_irq_test.sv
`timescale 1ns/1ps
`default_nettype none
module pcei_pad_config_ext_irq_test;
    import pcei_pkg::*;
    logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    pcei_addr_t paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, fb_pin, fb_rx, fb_pu, req_a, req_b, irq_pu, wake, irq;
    logic low_power = 1'b0, fb_drv = 1'b0, fb_val = 1'b1;
    logic [1:0] hold = 2'h0;
    pcei_pe_t pe_in, pe_out, pe_oe, pe_pu, tmr_in;
    pcei_pe_t tmr_out = 6'h00, tmr_oe = 6'h00, pe_ext = 6'h00;
    int fails = 0, check_count = 0, cycles = 0;

    pcei_pad_config_ext_irq pcei_pad_config_ext_irq_i (.i_clk_sys(clk), .i_srst(srst),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_fbrx_pin(fb_pin), .o_fbrx_rx(fb_rx), .o_fbrx_pullup_en(fb_pu),
        .i_low_power(low_power), .i_ext_int_req_a(req_a), .i_ext_int_req_b(req_b),
        .o_irq_pullup_en(irq_pu), .o_ext_wake(wake), .o_irq(irq), .i_port_e_in(pe_in),
        .o_port_e_out(pe_out), .o_port_e_oe(pe_oe), .o_port_e_pullup_en(pe_pu),
        .i_timer_out(tmr_out), .i_timer_oe(tmr_oe), .o_timer_in(tmr_in));
    pcei_ext_model pcei_ext_model_i (.i_clk_sys(clk), .i_hold_low(hold),
        .i_irq_pullup_en(irq_pu), .i_fb_drive(fb_drv), .i_fb_val(fb_val),
        .i_fb_pullup_en(fb_pu), .i_pe_out(pe_out), .i_pe_oe(pe_oe), .i_pe_ext(pe_ext),
        .o_req_a(req_a), .o_req_b(req_b), .o_fb_pin(fb_pin), .o_pe_pad(pe_in));

    // ------------------------------------------------------------------
    // clock, timeout and helpers
    // ------------------------------------------------------------------
    always #10 clk = ~clk;

    // the whole run needs a few hundred cycles; a hang ends at cycle 20000, far above that
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            tally_and_finish();
        end
    end

    function automatic pcei_pe_t pe_mux(pcei_pe_t sel, pcei_pe_t gpio, pcei_pe_t tmr);
        return (sel & gpio) | (~sel & tmr);
    endfunction : pe_mux

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // one apb transfer, request held until pready is seen at an edge
    task automatic apb(input logic wr, input pcei_addr_t a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input pcei_addr_t a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        #1;
    endtask : wr

    task automatic rdchk(input string nm, input pcei_addr_t a, input logic [31:0] exp,
                         input logic exp_err);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(nm, r, exp);
        chk({nm, " error"}, 32'(e), 32'(exp_err));
    endtask : rdchk

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        pcei_pe_t s, d, o, x, p;
        void'($urandom(32'h0fde));
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        tmr_out <= pcei_pe_t'($urandom);
        tmr_oe <= pcei_pe_t'($urandom);
        @(posedge clk);
        #1;
        chk("fbrx pullup", 32'(fb_pu), 32'h1);
        chk("fbrx level", 32'(fb_rx), 32'h1);
        chk("irq pullup", 32'(irq_pu), 32'h1);
        chk("pe pullup", 32'(pe_pu), 32'(PEPU_RST));
        chk("pe out", 32'(pe_out), 32'(tmr_out));
        chk("pe oe", 32'(pe_oe), 32'(tmr_oe));
        rdchk("pud", OFF_PUD, 32'(PUD_RST), 1'b0);
        rdchk("pepu", OFF_PEPU, 32'(PEPU_RST), 1'b0);
        rdchk("pesel", OFF_PESEL, 32'(PESEL_RST), 1'b0);
        rdchk("unmapped", 8'h28, 32'h0, 1'b1);
        rdchk("misaligned", 8'h02, 32'h0, 1'b1);
        // pull-up disable bits, every combination
        for (int v = 0; v < 4; v++) begin
            wr(OFF_PUD, 32'(v));
            chk("fbrx pullup", 32'(fb_pu), 32'(!v[0]));
            chk("irq pullup", 32'(irq_pu), 32'(!v[1]));
        end
        repeat (3) begin
            s = pcei_pe_t'($urandom);
            wr(OFF_PEPU, 32'(s));
            chk("pe pullup", 32'(pe_pu), 32'(s));
        end
        // a second reset in mid-run restores the pull-ups
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        chk("fbrx pullup", 32'(fb_pu), 32'h1);
        chk("pe pullup", 32'(pe_pu), 32'(PEPU_RST));
        @(posedge clk);
        fb_drv <= 1'b1;
        fb_val <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("fbrx level", 32'(fb_rx), 32'h0);
        @(posedge clk);
        fb_drv <= 1'b0;
        // mixed timer and gpio pins, random direction and data;
        // the first pass puts every pin on gpio as a corner case
        for (int k = 0; k < 6; k++) begin
            s = (k == 0) ? 6'h3f : pcei_pe_t'($urandom);
            d = pcei_pe_t'($urandom);
            o = pcei_pe_t'($urandom);
            x = pcei_pe_t'($urandom);
            pe_ext <= x;
            tmr_out <= pcei_pe_t'($urandom);
            wr(OFF_PESEL, 32'(s));
            wr(OFF_PEDIR, 32'(d));
            wr(OFF_PEDO, 32'(o));
            chk("pe oe", 32'(pe_oe), 32'(pe_mux(s, d, tmr_oe)));
            chk("pe out", 32'(pe_out), 32'(pe_mux(s, o, tmr_out)));
            p = pe_mux(pe_mux(s, d, tmr_oe), pe_mux(s, o, tmr_out), x);
            // new pad levels need two edges through the synchronisers
            repeat (2) @(posedge clk);
            #1;
            chk("timer in", 32'(tmr_in), 32'(p));
            rdchk("pe pins", OFF_PEDI, 32'(p), 1'b0);
        end
        // level on request a, then falling edge on request b
        wr(OFF_IEN, 32'h3);
        for (int m = 0; m < 2; m++) begin
            wr(OFF_IRQCFG, m ? 32'h3 : 32'h0);
            wr(OFF_ICLR, 32'h3);
            @(posedge clk);
            hold <= 2'(1 << m);
            repeat (2) @(posedge clk);
            #1;
            chk("irq early", 32'(irq), 32'h0);
            @(posedge clk);
            #1;
            chk("irq set", 32'(irq), 32'h1);
            wr(OFF_IEN, 32'h0);
            chk("irq masked", 32'(irq), 32'h0);
            wr(OFF_IEN, 32'h3);
            wr(OFF_ICLR, 32'(1 << m));
            rdchk("status held low", OFF_ISTAT, m ? 32'h0 : 32'h1, 1'b0);
            hold <= 2'h0;
            repeat (3) @(posedge clk);
            wr(OFF_ICLR, 32'h3);
            rdchk("status cleared", OFF_ISTAT, 32'h0, 1'b0);
        end
        // low power: wake follows the pin with no clock edge in between
        low_power <= 1'b1;
        wr(OFF_IEN, 32'h3);
        @(posedge clk);
        hold <= 2'h2;
        #1;
        chk("wake", 32'(wake), 32'h1);
        repeat (2) @(posedge clk);
        hold <= 2'h0;
        #1;
        chk("wake released", 32'(wake), 32'h0);
        tally_and_finish();
    end
endmodule : pcei_pad_config_ext_irq_test
`default_nettype wire
